// [adc_window_pkg.sv]
// Constants and carrier types for the converter window-compare block.
// Assumes a byte-wide special-function-register bus on the system clock.
package adc_window_pkg;
    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GREATER_LO = 8'hC4;
    localparam logic [7:0] ADDR_GREATER_HI = 8'hC5;
    localparam logic [7:0] ADDR_LESS_LO = 8'hC6;
    localparam logic [7:0] ADDR_LESS_HI = 8'hC7;
    localparam logic [7:0] ADDR_CONTROL = 8'hE8;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] GREATER_LO_RESET = 8'hFF;
    localparam logic [7:0] GREATER_HI_RESET = 8'hFF;
    localparam logic [7:0] LESS_LO_RESET = 8'h00;
    localparam logic [7:0] LESS_HI_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Control register field positions and source value, result width and left-justify shift
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_TRACK = 6;
    localparam int BIT_DONE = 5;
    localparam int BIT_BUSY = 4;
    localparam int BIT_SRC_HI = 3;
    localparam int BIT_SRC_LO = 2;
    localparam int BIT_WINDOW = 1;
    localparam int BIT_JUSTIFY = 0;
    localparam logic [1:0] SRC_SOFTWARE = 2'h0;
    localparam int RESULT_W = 10;
    localparam int LEFT_SHIFT = 6;
    // ----------------------------------------------------------------
    // Carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_req_t;
endpackage

// [adc_window_detector.sv]
// Window-compare logic and converter control register beside a 10-bit converter.
// Assumes the converter reports completion on the system clock with a done pulse.
`timescale 1ns/100ps
module adc_window_detector (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire adc_window_pkg::sfr_req_t sfr_i,
    output logic [7:0] rdata_o,
    input wire logic start_event_i,
    input wire logic conv_done_i,
    input wire logic [adc_window_pkg::RESULT_W-1:0] result_i,
    output logic conv_start_o,
    output logic conv_enable_o,
    output logic left_justify_o,
    output logic window_flag_o
);
    import adc_window_pkg::*;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] gt_lo_r, gt_hi_r, lt_lo_r, lt_hi_r, ctl_r;
    logic [7:0] ctl_nxt, rdata_nxt;
    logic conv_start_r;

    // Strobe is an argument so the decode re-evaluates when only the strobe moves
    function automatic logic hit(input logic wr, input logic [7:0] addr, input logic [7:0] a);
        return wr && (addr == a);
    endfunction

    wire wr_gt_lo = hit(sfr_i.wr, sfr_i.addr, ADDR_GREATER_LO);
    wire wr_gt_hi = hit(sfr_i.wr, sfr_i.addr, ADDR_GREATER_HI);
    wire wr_lt_lo = hit(sfr_i.wr, sfr_i.addr, ADDR_LESS_LO);
    wire wr_lt_hi = hit(sfr_i.wr, sfr_i.addr, ADDR_LESS_HI);
    wire wr_ctl = hit(sfr_i.wr, sfr_i.addr, ADDR_CONTROL);

    wire [15:0] gt_word = {gt_hi_r, gt_lo_r};
    wire [15:0] lt_word = {lt_hi_r, lt_lo_r};

    // ----------------------------------------------------------------
    // Window compare
    // ----------------------------------------------------------------
    wire [15:0] res_right = {{LEFT_SHIFT{1'b0}}, result_i};
    wire [15:0] res_left = {result_i, {LEFT_SHIFT{1'b0}}};
    wire [15:0] res_word = ctl_r[BIT_JUSTIFY] ? res_left : res_right;
    wire above_gt = res_word > gt_word;
    wire below_lt = res_word < lt_word;
    wire inside_mode = lt_word > gt_word;
    wire match = inside_mode ? (above_gt && below_lt) : (above_gt || below_lt);
    wire finish = conv_done_i && ctl_r[BIT_BUSY];
    wire win_set = finish && match;

    // ----------------------------------------------------------------
    // Start and busy
    // ----------------------------------------------------------------
    wire sw_start = wr_ctl && sfr_i.wdata[BIT_BUSY]
        && ctl_r[BIT_SRC_HI:BIT_SRC_LO] == SRC_SOFTWARE;
    wire hw_start = start_event_i && ctl_r[BIT_SRC_HI:BIT_SRC_LO] != SRC_SOFTWARE;
    wire enabled_nxt = wr_ctl ? sfr_i.wdata[BIT_ENABLE] : ctl_r[BIT_ENABLE];
    wire start = (sw_start || hw_start) && enabled_nxt && !ctl_r[BIT_BUSY];
    wire busy_nxt = start || (ctl_r[BIT_BUSY] && !conv_done_i && enabled_nxt);
    wire flag_keep = wr_ctl ? sfr_i.wdata[BIT_WINDOW] : ctl_r[BIT_WINDOW];
    wire done_keep = wr_ctl ? sfr_i.wdata[BIT_DONE] : ctl_r[BIT_DONE];

    always_comb begin
        ctl_nxt = wr_ctl ? sfr_i.wdata : ctl_r;
        ctl_nxt[BIT_BUSY] = busy_nxt;
        ctl_nxt[BIT_WINDOW] = win_set || flag_keep;
        ctl_nxt[BIT_DONE] = finish || done_keep;
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_i.rd) begin
            unique case (sfr_i.addr)
                ADDR_GREATER_LO: rdata_nxt = gt_lo_r;
                ADDR_GREATER_HI: rdata_nxt = gt_hi_r;
                ADDR_LESS_LO: rdata_nxt = lt_lo_r;
                ADDR_LESS_HI: rdata_nxt = lt_hi_r;
                ADDR_CONTROL: rdata_nxt = ctl_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gt_lo_r <= GREATER_LO_RESET;
            gt_hi_r <= GREATER_HI_RESET;
            lt_lo_r <= LESS_LO_RESET;
            lt_hi_r <= LESS_HI_RESET;
            ctl_r <= CONTROL_RESET;
            rdata_o <= 8'h00;
            conv_start_r <= 1'b0;
        end else begin
            if (wr_gt_lo) gt_lo_r <= sfr_i.wdata;
            if (wr_gt_hi) gt_hi_r <= sfr_i.wdata;
            if (wr_lt_lo) lt_lo_r <= sfr_i.wdata;
            if (wr_lt_hi) lt_hi_r <= sfr_i.wdata;
            ctl_r <= ctl_nxt;
            rdata_o <= rdata_nxt;
            conv_start_r <= start;
        end
    end

    assign conv_start_o = conv_start_r;
    assign conv_enable_o = ctl_r[BIT_ENABLE];
    assign left_justify_o = ctl_r[BIT_JUSTIFY];
    assign window_flag_o = ctl_r[BIT_WINDOW];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    compare_sets_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] && match |=> window_flag_o)
        else $error("window match did not raise the flag");

    inside_band_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] && lt_word > gt_word && res_word > gt_word
        && res_word < lt_word |=> window_flag_o)
        else $error("inside band result not flagged");

    outside_band_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] && !window_flag_o && !wr_ctl && lt_word > gt_word
        && res_word <= gt_word |=> !window_flag_o)
        else $error("outside result flagged in inside mode");

    limit_bytes_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_gt_hi |=> gt_word[15:8] == $past(sfr_i.wdata) && gt_word[7:0] == $past(gt_lo_r))
        else $error("greater-than high byte write disturbed word");

    poll_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_i.rd && sfr_i.addr == ADDR_CONTROL |=> rdata_o[BIT_WINDOW] == $past(window_flag_o))
        else $error("polled flag differs from flag");

    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        window_flag_o && !(wr_ctl && !sfr_i.wdata[BIT_WINDOW]) |=> window_flag_o)
        else $error("window flag dropped without software clear");

    gt_reset_a: assert property (@(posedge clk_i)
        $rose(rstn_i) |-> gt_lo_r == GREATER_LO_RESET)
        else $error("greater-than low byte reset value wrong");

    lt_reset_a: assert property (@(posedge clk_i)
        $rose(rstn_i) |-> lt_hi_r == LESS_HI_RESET)
        else $error("less-than high byte reset value wrong");

    shutdown_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !conv_enable_o && !(wr_ctl && sfr_i.wdata[BIT_ENABLE]) |=> !conv_start_o)
        else $error("conversion started while disabled");

    busy_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        start |=> conv_start_o && ctl_r[BIT_BUSY] ##1 !conv_start_o)
        else $error("start write did not set busy");

    busy_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] |=> !ctl_r[BIT_BUSY])
        else $error("completion did not clear busy");

    done_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] |=> ctl_r[BIT_DONE])
        else $error("completion did not set the done flag");

    event_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        start_event_i && ctl_r[BIT_SRC_HI:BIT_SRC_LO] != SRC_SOFTWARE && conv_enable_o
        && !ctl_r[BIT_BUSY] && !wr_ctl |=> conv_start_o && ctl_r[BIT_BUSY])
        else $error("start event did not begin a conversion");

    source_refused_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ctl && sfr_i.wdata[BIT_BUSY] && ctl_r[BIT_SRC_HI:BIT_SRC_LO] != SRC_SOFTWARE
        && !start_event_i |=> !conv_start_o)
        else $error("busy write started a conversion under event source");

    write_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ctl && !sfr_i.wdata[BIT_BUSY] && !start_event_i |=> !conv_start_o)
        else $error("writing zero to busy started a conversion");

    busy_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctl_r[BIT_BUSY] && !conv_done_i && enabled_nxt |=> ctl_r[BIT_BUSY])
        else $error("busy fell before completion");

    disable_drop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctl_r[BIT_BUSY] && !enabled_nxt |=> !ctl_r[BIT_BUSY] && !conv_start_o)
        else $error("conversion kept running after disable");

    enable_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ctl |=> conv_enable_o == $past(sfr_i.wdata[BIT_ENABLE]))
        else $error("enable output does not follow the control write");

    lt_bytes_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_lt_lo |=> lt_word[7:0] == $past(sfr_i.wdata) && lt_word[15:8] == $past(lt_hi_r))
        else $error("less-than low byte write disturbed word");

    gt_low_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_gt_lo |=> gt_word[7:0] == $past(sfr_i.wdata) && gt_word[15:8] == $past(gt_hi_r))
        else $error("greater-than low byte is not the low half");

    lt_high_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_lt_hi |=> lt_word[15:8] == $past(sfr_i.wdata) && lt_word[7:0] == $past(lt_lo_r))
        else $error("less-than high byte is not the high half");

    outside_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] && lt_word <= gt_word
        && (res_word > gt_word || res_word < lt_word) |=> window_flag_o)
        else $error("outside band result not flagged");

    outside_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        conv_done_i && ctl_r[BIT_BUSY] && !window_flag_o && !wr_ctl && lt_word <= gt_word
        && res_word <= gt_word && res_word >= lt_word |=> !window_flag_o)
        else $error("inside result flagged in outside mode");

    flag_origin_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(window_flag_o) |-> $past(conv_done_i && ctl_r[BIT_BUSY] && match
        || wr_ctl && sfr_i.wdata[BIT_WINDOW]))
        else $error("window flag rose without a match");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ctl && !sfr_i.wdata[BIT_WINDOW] && !(conv_done_i && ctl_r[BIT_BUSY] && match)
        |=> !window_flag_o)
        else $error("software clear did not drop the window flag");

    poll_control_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_i.rd && sfr_i.addr == ADDR_CONTROL |=> rdata_o == $past(ctl_r))
        else $error("control read returned wrong value");
endmodule

// [adc_window_detector_tb_top.sv]
// Self-checking testbench for the converter window-compare block.
// Assumes the package constants and the register-bus timing of the design hand-over.
`timescale 1ns/100ps
module adc_window_detector_tb_top;
    import adc_window_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    sfr_req_t sfr_i = '0;
    logic start_event_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic [RESULT_W-1:0] result_i = '0;
    logic [7:0] rdata_o;
    logic conv_start_o, conv_enable_o, left_justify_o, window_flag_o;
    int errors = 0;
    int checks_done = 0;

    adc_window_detector u_adc_window_detector (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_i(sfr_i),
        .rdata_o(rdata_o), .start_event_i(start_event_i), .conv_done_i(conv_done_i),
        .result_i(result_i), .conv_start_o(conv_start_o), .conv_enable_o(conv_enable_o),
        .left_justify_o(left_justify_o), .window_flag_o(window_flag_o));

    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        sfr_i = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk_i);
        sfr_i.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        sfr_i = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk_i);
        sfr_i.rd = 1'b0;
        chk(rdata_o, exp, "read");
    endtask
    task automatic lim(input logic [15:0] gt, input logic [15:0] lt);
        wr(ADDR_GREATER_LO, gt[7:0]);
        wr(ADDR_GREATER_HI, gt[15:8]);
        wr(ADDR_LESS_LO, lt[7:0]);
        wr(ADDR_LESS_HI, lt[15:8]);
    endtask
    task automatic done_pulse(input logic [9:0] res);
        @(negedge clk_i);
        conv_done_i = 1'b1;
        result_i = res;
        @(negedge clk_i);
        conv_done_i = 1'b0;
    endtask
    task automatic event_pulse(input logic exp);
        @(negedge clk_i);
        start_event_i = 1'b1;
        @(negedge clk_i);
        start_event_i = 1'b0;
        chk({7'h00, conv_start_o}, {7'h00, exp}, "event start");
    endtask
    // Starts one conversion, finishes it, polls the sticky flag, then clears it
    task automatic conv(input logic [7:0] ctl, input logic [9:0] res, input logic flag);
        wr(ADDR_CONTROL, ctl | 8'h10);
        chk({7'h00, conv_start_o}, 8'h01, "start");
        done_pulse(res);
        chk({7'h00, window_flag_o}, {7'h00, flag}, "flag");
        repeat (3) @(negedge clk_i);
        rd(ADDR_CONTROL, ctl | 8'h20 | {6'h00, flag, 1'b0});
        wr(ADDR_CONTROL, ctl);
        chk({7'h00, window_flag_o}, 8'h00, "clear");
    endtask
    task automatic end_sim;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] addrs [6] = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8, 8'h00};
        logic [7:0] resets [6] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        foreach (addrs[i]) rd(addrs[i], resets[i]);
        lim(16'h12A5, 16'h3C96);
        rd(ADDR_GREATER_LO, 8'hA5);
        rd(ADDR_GREATER_HI, 8'h12);
        rd(ADDR_LESS_LO, 8'h96);
        rd(ADDR_LESS_HI, 8'h3C);
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h00);
        wr(ADDR_CONTROL, 8'h10);
        chk({conv_start_o, conv_enable_o}, 8'h00, "disabled start");
        rd(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        chk({7'h00, conv_enable_o}, 8'h01, "enable");
        lim(16'h0100, 16'h0200);
        conv(8'h80, 10'h150, 1'b1);
        conv(8'h80, 10'h100, 1'b0);
        conv(8'h80, 10'h200, 1'b0);
        conv(8'h80, 10'h250, 1'b0);
        done_pulse(10'h150);
        rd(ADDR_CONTROL, 8'h80);
        lim(16'h0200, 16'h0100);
        conv(8'h80, 10'h050, 1'b1);
        conv(8'h80, 10'h250, 1'b1);
        conv(8'h80, 10'h150, 1'b0);
        conv(8'h80, 10'h200, 1'b0);
        lim(16'h4000, 16'h8000);
        conv(8'h81, 10'h1FF, 1'b1);
        chk({7'h00, left_justify_o}, 8'h01, "justify");
        conv(8'h81, 10'h200, 1'b0);
        // Event start source: busy write refused, event starts, zero write keeps busy
        wr(ADDR_CONTROL, 8'h84);
        wr(ADDR_CONTROL, 8'h94);
        chk({7'h00, conv_start_o}, 8'h00, "source refused");
        event_pulse(1'b1);
        wr(ADDR_CONTROL, 8'h84);
        rd(ADDR_CONTROL, 8'h94);
        done_pulse(10'h3FF);
        rd(ADDR_CONTROL, 8'hA4);
        // Clearing enable mid-conversion drops busy and blocks further starts
        event_pulse(1'b1);
        wr(ADDR_CONTROL, 8'h04);
        rd(ADDR_CONTROL, 8'h04);
        event_pulse(1'b0);
        end_sim();
    end

    initial begin
        #(50 * 4000);
        errors++;
        end_sim();
    end
endmodule
